/* File: sbcw_regs.sv */
// watchdog, bus and failure-output control bank behind an AHB-Lite slave
// assumes: single-word transfers, one clock, mode and event inputs synchronous
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
// Contract
// R1 - clearing the software failure enable never turns off failure-driven outputs
// R2 - restart entry clears a set software failure enable and outputs
// R3 - soft reset keeps aux voltage cfg and load share; power-on clears them
// R4 - host writes watchdog control with even parity over bits 7:0
// R5 - watchdog control resets to 0x14; restart forces x0xx 0100
// R6 - bit 6 low keeps watchdog active in stop; device may update it
// R7 - bit 5 picks time-out (0) or window (1) watchdog
// R8 - bit 4 starts watchdog with long open window after bus wake
// R9 - bits 2:0 pick period 10..1000 ms; code 111 reserved
// R10 - reserved bits are read-only and read zero
// R11 - bus control bits 1:0 set CAN mode; device may update them
// R12 - fail-safe entry forces bus control xxx0 0001 and wake control x0x0 0111; code also clears wake bit 5, giving x000 0111
// R13 - restart clears upper six bus control bits; CAN mode set by cause
// R14 - bus control two bit 5 selects low or high peak threshold
// R15 - peak threshold writable in init and normal, read-only in stop
// R16 - blocked peak write in stop raises no access error nor interrupt
// R17 - stop-mode load share acts with peak behaviour in stop mode
// R18 - global bit 0: only wake sources interrupt; 1: all status bits
// R19 - registers are 8 bits, 7-bit addresses, over the configuration port
module sbcw_regs (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  input wire logic I_SOFT_RESET,
  input wire logic I_RESTART_ENTRY,
  input wire logic I_FAILSAFE_ENTRY,
  input wire logic [1:0] I_RESTART_CAN_MODE,
  input wire logic I_FAILURE_EVENT,
  input wire logic I_WAKE_EVENT,
  input wire logic I_WD_STOP_UPDATE,
  output logic O_FAILURE_OUTPUTS,
  output logic [1:0] O_CAN_MODE,
  output logic O_PEAK_THRESH_HIGH,
  output logic O_WD_WINDOW,
  output logic O_WD_START_ON_BUS_WAKE,
  output logic O_WD_STOP_ACTIVE,
  output logic [31:0] O_WD_PERIOD_CYCLES,
  output logic O_STOP_LOAD_SHARE,
  output logic O_IRQ
);
  logic [7:0] hw_ctrl;
  logic [7:0] watchdog_control;
  logic [7:0] bus_one;
  logic [7:0] bus_two;
  logic [7:0] wake_two;
  logic [1:0] mode;
  logic failure_flag;
  logic [sbcw_pkg::IRQ_BITS-1:0] irq_stat;
  logic [sbcw_pkg::IRQ_BITS-1:0] irq_mask;
  logic dp_write;
  logic [6:0] dp_idx;
  logic dp_valid;
  logic [31:0] next_rdata;
  logic wr_en;
  logic [7:0] wd_data;
  logic [sbcw_pkg::IRQ_BITS-1:0] irq_set;
  logic [sbcw_pkg::IRQ_BITS-1:0] irq_eligible;
  logic peak_blocked;
  logic parity_ok;
  logic wd_window;
  logic wd_bus_wake;
  logic period_valid;
  logic [31:0] period_cycles;

  sbcw_wd_decode u_wd_decode (
    .i_setting(watchdog_control),
    .o_parity_ok(parity_ok),
    .o_window(wd_window),
    .o_start_on_bus_wake(wd_bus_wake),
    .o_period_valid(period_valid),
    .o_period_cycles(period_cycles)
  );

  // address phase capture; slave answers with zero wait states
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      dp_valid <= 1'b0;
      dp_write <= 1'b0;
      dp_idx <= 7'h00;
    end else if (I_HREADY) begin
      dp_valid <= I_HSEL && I_HTRANS[1];
      dp_write <= I_HWRITE;
      dp_idx <= I_HADDR[8:2]; // R19
    end
  end

  assign wr_en = dp_valid && dp_write;
  assign wd_data = I_HWDATA[7:0];
  // stop mode silently drops a peak write
  assign peak_blocked = (mode == sbcw_pkg::MODE_STOP); // R15

  // hardware control: aux voltage cfg and load share bits survive soft reset
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      hw_ctrl <= sbcw_pkg::HW_POR; // R3
    end else if (I_SOFT_RESET) begin
      hw_ctrl <= hw_ctrl & sbcw_pkg::HW_SOFT_KEEP; // R3
    end else if (I_RESTART_ENTRY) begin
      hw_ctrl[sbcw_pkg::HW_FO] <= 1'b0; // R2
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_HW_CTRL) begin
      hw_ctrl <= wd_data & sbcw_pkg::HW_MASK; // R10
    end
  end

  // watchdog control
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      watchdog_control <= sbcw_pkg::WD_POR; // R5
    end else if (I_SOFT_RESET) begin
      watchdog_control <= sbcw_pkg::WD_POR; // R5
    end else if (I_RESTART_ENTRY) begin
      watchdog_control <= (watchdog_control & sbcw_pkg::WD_RST_KEEP) | sbcw_pkg::WD_RST_SET; // R5
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_WATCHDOG_CONTROL) begin
      watchdog_control <= wd_data & sbcw_pkg::WD_MASK; // R10
    end else if (I_WD_STOP_UPDATE) begin
      watchdog_control[sbcw_pkg::WD_STM0] <= 1'b0; // R6
    end
  end

  // bus control one: can mode
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bus_one <= sbcw_pkg::BUS1_POR;
    end else if (I_SOFT_RESET) begin
      bus_one <= sbcw_pkg::BUS1_POR;
    end else if (I_FAILSAFE_ENTRY) begin
      bus_one <= sbcw_pkg::BUS1_FAILSAFE; // R12
    end else if (I_RESTART_ENTRY) begin
      bus_one <= {6'h00, I_RESTART_CAN_MODE}; // R13
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_BUS_ONE) begin
      bus_one <= wd_data & sbcw_pkg::BUS1_MASK; // R11
    end
  end

  // bus control two: peak threshold
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      bus_two <= sbcw_pkg::BUS2_POR;
    end else if (I_SOFT_RESET) begin
      bus_two <= sbcw_pkg::BUS2_POR;
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_BUS_TWO && !peak_blocked) begin
      bus_two <= wd_data & sbcw_pkg::BUS2_MASK; // R14
    end
  end

  // external wake control
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wake_two <= sbcw_pkg::WK2_POR;
    end else if (I_SOFT_RESET) begin
      wake_two <= sbcw_pkg::WK2_POR;
    end else if (I_FAILSAFE_ENTRY) begin
      wake_two <= (wake_two & sbcw_pkg::WK2_FS_KEEP) | sbcw_pkg::WK2_FS_SET; // R12
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_WAKE_TWO) begin
      wake_two <= wd_data & sbcw_pkg::WK2_MASK; // R10
    end
  end

  // device mode, written by software
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      mode <= sbcw_pkg::MODE_INIT;
    end else if (I_SOFT_RESET || I_RESTART_ENTRY) begin
      mode <= sbcw_pkg::MODE_NORMAL;
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_MODE && wd_data[1:0] != 2'h3) begin
      mode <= wd_data[1:0];
    end
  end

  // failure flag: set by failure, cleared by writing one, set wins
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      failure_flag <= 1'b0;
    end else if (I_FAILURE_EVENT) begin
      failure_flag <= 1'b1;
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_STATUS && wd_data[0]) begin
      failure_flag <= 1'b0; // R1
    end
  end

  // interrupt events
  always_comb begin
    irq_set = '0;
    irq_set[sbcw_pkg::IRQ_WAKE] = I_WAKE_EVENT;
    irq_set[sbcw_pkg::IRQ_FAIL] = I_FAILURE_EVENT;
    irq_set[sbcw_pkg::IRQ_WDPAR] = wr_en && dp_idx == sbcw_pkg::IDX_WATCHDOG_CONTROL
      && (^wd_data); // R4
    // unmapped index is an access error; blocked peak write is not
    irq_set[sbcw_pkg::IRQ_ACCESS] = dp_valid && !(dp_idx == sbcw_pkg::IDX_HW_CTRL
      || dp_idx == sbcw_pkg::IDX_WATCHDOG_CONTROL || dp_idx == sbcw_pkg::IDX_BUS_ONE
      || dp_idx == sbcw_pkg::IDX_BUS_TWO || dp_idx == sbcw_pkg::IDX_WAKE_TWO
      || dp_idx == sbcw_pkg::IDX_MODE || dp_idx == sbcw_pkg::IDX_IRQ_STAT
      || dp_idx == sbcw_pkg::IDX_IRQ_MASK || dp_idx == sbcw_pkg::IDX_STATUS); // R16
  end

  // eligible sources per global bit
  assign irq_eligible = wake_two[sbcw_pkg::WK2_GLOBAL] ? '1 : sbcw_pkg::IRQ_WAKE_SRC; // R18

  genvar gi;
  generate
    for (gi = 0; gi < sbcw_pkg::IRQ_BITS; gi++) begin : g_irq
      always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
          irq_stat[gi] <= 1'b0;
        end else if (irq_set[gi]) begin
          irq_stat[gi] <= 1'b1;
        end else if (wr_en && dp_idx == sbcw_pkg::IDX_IRQ_STAT && wd_data[gi]) begin
          irq_stat[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      irq_mask <= '0;
    end else if (wr_en && dp_idx == sbcw_pkg::IDX_IRQ_MASK) begin
      irq_mask <= wd_data[sbcw_pkg::IRQ_BITS-1:0];
    end
  end

  // read mux, reserved bits read zero
  always_comb begin
    next_rdata = 32'h0;
    if (I_HSEL && I_HTRANS[1] && !I_HWRITE) begin
      case (I_HADDR[8:2])
        sbcw_pkg::IDX_HW_CTRL: next_rdata[7:0] = hw_ctrl;
        sbcw_pkg::IDX_WATCHDOG_CONTROL: next_rdata[7:0] = watchdog_control;
        sbcw_pkg::IDX_BUS_ONE: next_rdata[7:0] = bus_one; // R10
        sbcw_pkg::IDX_BUS_TWO: next_rdata[7:0] = bus_two;
        sbcw_pkg::IDX_WAKE_TWO: next_rdata[7:0] = wake_two;
        sbcw_pkg::IDX_MODE: next_rdata[1:0] = mode;
        sbcw_pkg::IDX_IRQ_STAT: next_rdata[sbcw_pkg::IRQ_BITS-1:0] = irq_stat;
        sbcw_pkg::IDX_IRQ_MASK: next_rdata[sbcw_pkg::IRQ_BITS-1:0] = irq_mask;
        sbcw_pkg::IDX_STATUS: next_rdata[2:0] = {period_valid, parity_ok, failure_flag};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_HRDATA <= 32'h0;
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end else begin
      if (I_HREADY) begin
        O_HRDATA <= next_rdata;
      end
      O_HREADYOUT <= 1'b1;
      O_HRESP <= 1'b0;
    end
  end

  // registered outputs
  always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_FAILURE_OUTPUTS <= 1'b0;
      O_CAN_MODE <= sbcw_pkg::CAN_OFF;
      O_PEAK_THRESH_HIGH <= 1'b0;
      O_WD_WINDOW <= 1'b0;
      O_WD_START_ON_BUS_WAKE <= 1'b0;
      O_WD_STOP_ACTIVE <= 1'b1;
      O_WD_PERIOD_CYCLES <= 32'h0;
      O_STOP_LOAD_SHARE <= 1'b0;
      O_IRQ <= 1'b0;
    end else begin
      O_FAILURE_OUTPUTS <= hw_ctrl[sbcw_pkg::HW_FO] || failure_flag; // R1
      O_CAN_MODE <= bus_one[1:0]; // R11
      O_PEAK_THRESH_HIGH <= bus_two[sbcw_pkg::BUS2_PEAK]; // R14
      O_WD_WINDOW <= wd_window; // R7
      O_WD_START_ON_BUS_WAKE <= wd_bus_wake; // R8
      O_WD_STOP_ACTIVE <= !watchdog_control[sbcw_pkg::WD_STM0]; // R6
      O_WD_PERIOD_CYCLES <= period_cycles; // R9
      O_STOP_LOAD_SHARE <= hw_ctrl[sbcw_pkg::HW_LS] && hw_ctrl[sbcw_pkg::HW_LS_STP]
        && (mode == sbcw_pkg::MODE_STOP); // R17
      O_IRQ <= |(irq_stat & irq_mask & irq_eligible); // R18
    end
  end
endmodule : sbcw_regs

/* File: sbcw_pkg.sv */
// package: offsets, fields, reset values and codes of the watchdog/bus control bank
// assumes: 32-bit AHB-Lite slave, one register per aligned word
package sbcw_pkg;
  // register indices (7-bit serial addresses); byte address is four times the index
  localparam logic [6:0] IDX_HW_CTRL = 7'h02;
  localparam logic [6:0] IDX_WATCHDOG_CONTROL = 7'h03;
  localparam logic [6:0] IDX_BUS_ONE = 7'h04;
  localparam logic [6:0] IDX_BUS_TWO = 7'h05;
  localparam logic [6:0] IDX_WAKE_TWO = 7'h07;
  localparam logic [6:0] IDX_MODE = 7'h20;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h21;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h22;
  localparam logic [6:0] IDX_STATUS = 7'h23;
  // field positions
  localparam int HW_VCFG = 7;
  localparam int HW_FO = 5;
  localparam int HW_LS = 3;
  localparam int HW_LS_STP = 1;
  localparam int WD_CHK = 7;
  localparam int WD_STM0 = 6;
  localparam int WD_TYPE_SELECT = 5;
  localparam int WD_WKBUS = 4;
  localparam int BUS2_PEAK = 5;
  localparam int WK2_GLOBAL = 7;
  // writable masks, reserved bits are zero
  localparam logic [7:0] HW_MASK = 8'hfb;
  localparam logic [7:0] WD_MASK = 8'hf7;
  localparam logic [7:0] BUS1_MASK = 8'h03;
  localparam logic [7:0] BUS2_MASK = 8'h20;
  localparam logic [7:0] WK2_MASK = 8'ha7;
  // reset values
  localparam logic [7:0] HW_POR = 8'h00;
  localparam logic [7:0] HW_SOFT_KEEP = 8'h88;
  localparam logic [7:0] WD_POR = 8'h14;
  localparam logic [7:0] WD_RST_KEEP = 8'hb0;
  localparam logic [7:0] WD_RST_SET = 8'h04;
  localparam logic [7:0] BUS1_POR = 8'h00;
  localparam logic [7:0] BUS1_FAILSAFE = 8'h01;
  localparam logic [7:0] BUS2_POR = 8'h00;
  localparam logic [7:0] WK2_POR = 8'h07;
  localparam logic [7:0] WK2_FS_KEEP = 8'h80;
  localparam logic [7:0] WK2_FS_SET = 8'h07;
  // device modes
  localparam logic [1:0] MODE_INIT = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  // can modes
  localparam logic [1:0] CAN_OFF = 2'h0;
  localparam logic [1:0] CAN_WAKE = 2'h1;
  localparam logic [1:0] CAN_RXONLY = 2'h2;
  localparam logic [1:0] CAN_NORMAL = 2'h3;
  // interrupt status bits
  localparam int IRQ_BITS = 4;
  localparam int IRQ_WAKE = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_WDPAR = 2;
  localparam int IRQ_ACCESS = 3;
  localparam logic [3:0] IRQ_WAKE_SRC = 4'h1;
  // watchdog period table in ms, code 7 reserved
  localparam int WD_MS [0:7] = '{10, 20, 50, 100, 200, 500, 1000, 0};
  localparam int CLK_MHZ = 100;
endpackage : sbcw_pkg

/* File: sbcw_wd_decode.sv */
// watchdog setting decode: parity check, type and period in clock cycles
// assumes: setting comes from the control register, outputs are combinational
`timescale 1ns/100ps
module sbcw_wd_decode #(
  parameter int CYC_PER_MS = 1000 * sbcw_pkg::CLK_MHZ
) (
  input wire logic [7:0] i_setting,
  output logic o_parity_ok,
  output logic o_window,
  output logic o_start_on_bus_wake,
  output logic o_period_valid,
  output logic [31:0] o_period_cycles
);
  always_comb begin
    o_parity_ok = ~(^i_setting); // R4
    o_window = i_setting[sbcw_pkg::WD_TYPE_SELECT]; // R7
    o_start_on_bus_wake = i_setting[sbcw_pkg::WD_WKBUS]; // R8
    o_period_valid = (i_setting[2:0] != 3'h7); // R9
    o_period_cycles = 32'(sbcw_pkg::WD_MS[i_setting[2:0]] * CYC_PER_MS); // R9
  end
endmodule : sbcw_wd_decode

/* File: sbcw_regs_assertions.sv */
// checker: port-level properties of the watchdog and bus control bank
// assumes: bound onto sbcw_regs, one clock, asynchronous active-low reset
`timescale 1ns/100ps
module sbcw_regs_assertions (
  input wire logic I_CORE_CLK,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic I_SOFT_RESET,
  input wire logic I_RESTART_ENTRY,
  input wire logic I_FAILSAFE_ENTRY,
  input wire logic [1:0] I_RESTART_CAN_MODE,
  input wire logic I_FAILURE_EVENT,
  input wire logic I_WD_STOP_UPDATE,
  input wire logic O_HREADYOUT,
  input wire logic O_HRESP,
  input wire logic O_FAILURE_OUTPUTS,
  input wire logic [1:0] O_CAN_MODE,
  input wire logic O_WD_WINDOW,
  input wire logic O_WD_START_ON_BUS_WAKE,
  input wire logic O_WD_STOP_ACTIVE,
  input wire logic [31:0] O_WD_PERIOD_CYCLES
);
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RST_N);
  chk_bus_okay: assert property (O_HREADYOUT && !O_HRESP)
    else $error("bus slave stalled or answered with error");
  chk_fail_hold: assert property (I_FAILURE_EVENT && !I_SOFT_RESET |-> ##2 O_FAILURE_OUTPUTS)
    else $error("failure event did not drive the failure outputs");
  chk_wd_restart: assert property (I_RESTART_ENTRY && !I_SOFT_RESET |->
    ##2 O_WD_PERIOD_CYCLES == 32'h01312d00 && O_WD_STOP_ACTIVE)
    else $error("restart left wrong watchdog period or stop setting");
  chk_soft_wd: assert property (I_SOFT_RESET |-> ##2 O_WD_PERIOD_CYCLES == 32'h01312d00
    && O_WD_START_ON_BUS_WAKE && !O_WD_WINDOW)
    else $error("soft reset left wrong watchdog setting");
  chk_failsafe_can: assert property (I_FAILSAFE_ENTRY && !I_SOFT_RESET |->
    ##2 O_CAN_MODE == 2'h1)
    else $error("fail-safe entry did not make the transceiver wake capable");
  chk_restart_can: assert property (I_RESTART_ENTRY && !I_SOFT_RESET && !I_FAILSAFE_ENTRY
    |-> ##2 O_CAN_MODE == $past(I_RESTART_CAN_MODE, 2))
    else $error("restart did not load the requested transceiver mode");
  chk_period_map: assert property (O_WD_PERIOD_CYCLES inside {32'h00000000, 32'h000f4240,
    32'h001e8480, 32'h004c4b40, 32'h00989680, 32'h01312d00, 32'h02faf080, 32'h05f5e100})
    else $error("watchdog period outside the documented set");
  chk_stop_update: assert property (I_WD_STOP_UPDATE
    && !$past(I_HSEL && I_HTRANS[1] && I_HWRITE) |-> ##2 O_WD_STOP_ACTIVE)
    else $error("device update did not keep the watchdog active in stop");
endmodule : sbcw_regs_assertions

bind sbcw_regs sbcw_regs_assertions u_chk (.*);

/* File: sbcw_host.sv */
// host model: AHB-Lite master issuing single-word register transfers
// assumes: the one slave's ready is fed back as hready, clock shared with the bank
`timescale 1ns/100ps
module sbcw_host (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hung
);
  logic [31:0] rd_q;
  event rd_ev;
  initial begin
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = '0;
    hung = 1'b0;
  end
  // checksum bit balances bits 6:0 to even parity over the byte
  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction : par
  task automatic xfer(input logic w, input logic [6:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {23'h0, idx, 2'b00};
    hwrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) hung <= 1'b1;
    // released data lines do not keep showing the last word
    hwdata <= ~{24'h0, d};
    if (!w) begin
      rd_q = hrdata;
      ->rd_ev;
    end
  endtask : xfer
endmodule : sbcw_host

/* File: sbcw_regs_tb.sv */
// testbench: self-checking run of the watchdog and bus control bank
// assumes: host model drives the bus, checker is bound onto the bank
`timescale 1ns/100ps
module sbcw_regs_tb;
  localparam logic [6:0] RI [5] = '{sbcw_pkg::IDX_HW_CTRL, sbcw_pkg::IDX_WATCHDOG_CONTROL,
    sbcw_pkg::IDX_BUS_ONE, sbcw_pkg::IDX_BUS_TWO, sbcw_pkg::IDX_WAKE_TWO};
  localparam logic [7:0] RV [5] = '{8'h00, 8'h14, 8'h00, 8'h00, 8'h07};
  localparam logic [7:0] RM [5] = '{sbcw_pkg::HW_MASK, sbcw_pkg::WD_MASK, sbcw_pkg::BUS1_MASK,
    sbcw_pkg::BUS2_MASK, sbcw_pkg::WK2_MASK};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] ev = '0;
  logic [1:0] rm = 2'h0;
  logic hsel, hwrite, hrdy, hresp, hung, fo, pk, win, stw, sta, ls, irq;
  logic [1:0] htrans, can;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, per;
  logic [31:0] xq [$];
  logic [7:0] wv;
  logic [31:0] r;
  int num_errors = 0;
  int tests_run = 0;
  always #5 clk = ~clk;
  sbcw_host hst (.clk(clk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hung(hung));
  sbcw_regs dut (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hrdy),
    .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .I_SOFT_RESET(ev[0]),
    .I_RESTART_ENTRY(ev[1]), .I_FAILSAFE_ENTRY(ev[2]), .I_RESTART_CAN_MODE(rm),
    .I_FAILURE_EVENT(ev[3]), .I_WAKE_EVENT(ev[4]), .I_WD_STOP_UPDATE(ev[5]),
    .O_FAILURE_OUTPUTS(fo), .O_CAN_MODE(can), .O_PEAK_THRESH_HIGH(pk), .O_WD_WINDOW(win),
    .O_WD_START_ON_BUS_WAKE(stw), .O_WD_STOP_ACTIVE(sta), .O_WD_PERIOD_CYCLES(per),
    .O_STOP_LOAD_SHARE(ls), .O_IRQ(irq));
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    hst.xfer(1'b1, i, d);
    repeat (2) @(posedge clk);
  endtask : wr
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    xq.push_back({24'h0, e});
    hst.xfer(1'b0, i, 8'h00);
  endtask : rd
  task automatic pulse(input int b);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev[b] <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : pulse
  // read results are matched in order against the noted expectations
  always @(hst.rd_ev) cmp("rdata", xq.pop_front(), hst.rd_q);
  initial begin
    for (int k = 0; k < 20000 && !hung; k++) @(posedge clk);
    num_errors++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h8026));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 5; k++) rd(RI[k], RV[k]);
    for (int k = 0; k < 5; k++) wr(RI[k], 8'hff);
    for (int k = 0; k < 5; k++) rd(RI[k], RM[k]);
    rd(7'h11, 8'h00);
    cmp("can", 32'(can), 32'h3);
    cmp("peak", 32'(pk), 32'h1);
    cmp("period", per, 32'h0);
    pulse(3);
    wr(sbcw_pkg::IDX_HW_CTRL, 8'h00);
    cmp("fo", 32'(fo), 32'h1);
    wr(sbcw_pkg::IDX_STATUS, 8'h01);
    cmp("fo", 32'(fo), 32'h0);
    wr(sbcw_pkg::IDX_IRQ_MASK, 8'h0f);
    cmp("irq", 32'(irq), 32'h1);
    wr(sbcw_pkg::IDX_WAKE_TWO, 8'h07);
    cmp("irq", 32'(irq), 32'h0);
    pulse(4);
    cmp("irq", 32'(irq), 32'h1);
    wr(sbcw_pkg::IDX_IRQ_STAT, 8'h0f);
    cmp("irq", 32'(irq), 32'h0);
    for (int c = 0; c < 8; c++) begin
      r = $urandom;
      wv = hst.par({1'b0, r[1:0], 1'b0, 3'(c)});
      wr(sbcw_pkg::IDX_WATCHDOG_CONTROL, wv);
      cmp("period", per, 32'(sbcw_pkg::WD_MS[c] * sbcw_pkg::CLK_MHZ * 1000));
      cmp("window", 32'(win), 32'(r[1]));
      cmp("buswake", 32'(stw), 32'(r[0]));
    end
    wr(sbcw_pkg::IDX_WATCHDOG_CONTROL, wv ^ 8'h80);
    rd(sbcw_pkg::IDX_IRQ_STAT, 8'h04);
    wv = hst.par({1'b1, wv[5:0]});
    wr(sbcw_pkg::IDX_WATCHDOG_CONTROL, wv);
    cmp("stopactive", 32'(sta), 32'h0);
    rd(sbcw_pkg::IDX_STATUS, 8'h02);
    pulse(5);
    cmp("stopactive", 32'(sta), 32'h1);
    wv[6] = 1'b0;
    wr(sbcw_pkg::IDX_HW_CTRL, 8'h20);
    rm <= r[3:2];
    pulse(1);
    cmp("fo", 32'(fo), 32'h0);
    rd(sbcw_pkg::IDX_HW_CTRL, 8'h00);
    rd(sbcw_pkg::IDX_WATCHDOG_CONTROL, (wv & 8'hb0) | 8'h04);
    rd(sbcw_pkg::IDX_BUS_ONE, {6'h0, rm});
    wr(sbcw_pkg::IDX_BUS_ONE, 8'h03);
    wr(sbcw_pkg::IDX_WAKE_TWO, 8'ha0);
    pulse(2);
    rd(sbcw_pkg::IDX_BUS_ONE, 8'h01);
    rd(sbcw_pkg::IDX_WAKE_TWO, 8'h87);
    wr(sbcw_pkg::IDX_BUS_TWO, 8'h00);
    rd(sbcw_pkg::IDX_BUS_TWO, 8'h00);
    wr(sbcw_pkg::IDX_HW_CTRL, 8'h8a);
    wr(sbcw_pkg::IDX_MODE, 8'h02);
    wr(sbcw_pkg::IDX_MODE, 8'h03);
    rd(sbcw_pkg::IDX_MODE, 8'h02);
    wr(sbcw_pkg::IDX_IRQ_STAT, 8'h0f);
    wr(sbcw_pkg::IDX_BUS_TWO, 8'hff);
    rd(sbcw_pkg::IDX_BUS_TWO, 8'h00);
    rd(sbcw_pkg::IDX_IRQ_STAT, 8'h00);
    cmp("irq", 32'(irq), 32'h0);
    cmp("loadshare", 32'(ls), 32'h1);
    pulse(0);
    rd(sbcw_pkg::IDX_HW_CTRL, 8'h88);
    rd(sbcw_pkg::IDX_WATCHDOG_CONTROL, 8'h14);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(sbcw_pkg::IDX_HW_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    stop_test();
  end
endmodule : sbcw_regs_tb
